// *** include/eeap_pkg.sv ***
package eeap_pkg;
  localparam int DATA_W    = 26;
  localparam int WORD_W    = 32;
  localparam int CHECK_W   = 6;
  localparam int ADDR_W    = 6;
  localparam int DATA_MSB  = 25;
  localparam int CHECK_LSB = 26;
  localparam int MEM_DEPTH = 64;
  localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;

  typedef enum logic [3:0] {
    EEAP_IDLE  = 4'b0001,
    EEAP_READ  = 4'b0010,
    EEAP_WRITE = 4'b0100,
    EEAP_DONE  = 4'b1000
  } eeap_state_t;
endpackage

// *** core/eeap_enc.sv ***
`timescale 1ns/1ps
// Computes the six check bits of a 26-bit data word: five Hamming parities
// over the (31,26) layout plus one overall parity for double-error detection.
module eeap_enc
  import eeap_pkg::*;
(
  input  wire logic [DATA_W-1:0]  data,
  output logic      [CHECK_W-1:0] check
);
  function automatic logic [30:0] spread(input logic [DATA_W-1:0] d);
    logic [30:0] cw;
    int          k;
    cw = '0;
    k  = 0;
    for (int p = 1; p <= 31; p++) begin
      if ((p & (p - 1)) != 0) begin
        cw[p-1] = d[k];
        k++;
      end
    end
    return cw;
  endfunction

  logic [30:0] cw;
  assign cw = spread(data);

  genvar i;
  generate
    for (i = 0; i < 5; i++) begin : g_par
      logic [30:0] sel;
      for (genvar p = 1; p <= 31; p++) begin : g_sel
        assign sel[p-1] = ((p >> i) & 1) != 0;
      end
      assign check[i] = ^(cw & sel);
    end
  endgenerate

  assign check[5] = (^data) ^ (^check[4:0]);
endmodule

// *** core/eeap_dec.sv ***
`timescale 1ns/1ps
// Checks a stored word and corrects a single flipped bit; a double error is
// reported and the data is passed uncorrected.
module eeap_dec
  import eeap_pkg::*;
(
  input  wire logic [WORD_W-1:0] word,
  output logic      [DATA_W-1:0] data,
  output logic                   singleErr,
  output logic                   doubleErr
);
  logic [CHECK_W-1:0] calc;
  logic [4:0]         syn;
  logic               parErr;

  eeap_enc uEnc (
    .data  (word[DATA_MSB:0]),
    .check (calc)
  );

  assign syn    = calc[4:0] ^ word[CHECK_LSB +: 5];
  assign parErr = calc[5] ^ word[WORD_W-1] ^ (^syn);

  // Maps a syndrome position back to a data index.
  function automatic logic [DATA_W-1:0] flipMask(input logic [4:0] s);
    logic [DATA_W-1:0] m;
    int                k;
    m = '0;
    k = 0;
    for (int p = 1; p <= 31; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (s == 5'(p)) begin
          m[k] = 1'b1;
        end
        k++;
      end
    end
    return m;
  endfunction

  always_comb begin
    singleErr = 1'b0;
    doubleErr = 1'b0;
    data      = word[DATA_MSB:0];
    if (syn != 5'h00 && !parErr) begin
      doubleErr = 1'b1;
    end else if (syn != 5'h00 || parErr) begin
      singleErr = 1'b1;
      data      = word[DATA_MSB:0] ^ flipMask(syn);
    end
  end
endmodule

// *** core/eeap_path.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Bypass input turns checking on or off.
// - Checked reads return only data bits 25:0.
// - Single error corrected, single flag set.
// - Double error leaves stored word unchanged, flagged.
// - Double error forces analog output high-impedance.
// - Checked writes take 26 data bits.
// - Checked writes store computed check bits.
// - Bypassed reads return full 32-bit word.
// - Bypassed reads deliver stored check bits.
// - Bypassed writes store 32 bits verbatim.
// - Detected error sets its status flag.
// - Flags read-only, cleared by status read.
module eeap_path
  import eeap_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic              eccBypass,
  input  wire logic              reqValid,
  input  wire logic              reqWrite,
  input  wire logic [ADDR_W-1:0] reqAddr,
  input  wire logic [WORD_W-1:0] reqWdata,
  input  wire logic              statusRead,
  output logic                   rspValid_q,
  output logic      [WORD_W-1:0] rspRdata_q,
  output logic                   busy_q,
  output logic                   singleFlag_q,
  output logic                   dualFlag_q,
  output logic      [1:0]        statusRdata_q,
  output logic                   outHighZ_q
);
  logic [WORD_W-1:0] mem [MEM_DEPTH];
  eeap_state_t       state_q;
  logic [ADDR_W-1:0] addr_q;
  logic [WORD_W-1:0] wdata_q;
  logic              write_q;
  logic              bypass_q;
  logic [WORD_W-1:0] rawWord_q;
  logic [CHECK_W-1:0] genCheck;
  logic [DATA_W-1:0] decData;
  logic              decSingle;
  logic              decDouble;
  logic              evSingle;
  logic              evDouble;

  // True in the cycle in which a finished read hands its word over.
  function automatic logic readDone(input eeap_state_t st, input logic wr);
    return st == EEAP_DONE && !wr;
  endfunction

  eeap_enc uEnc (
    .data  (wdata_q[DATA_MSB:0]),
    .check (genCheck)
  );

  eeap_dec uDec (
    .word      (rawWord_q),
    .data      (decData),
    .singleErr (decSingle),
    .doubleErr (decDouble)
  );

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_q <= EEAP_IDLE;
    end else begin
      unique case (state_q)
        EEAP_IDLE: begin
          if (reqValid) begin
            state_q <= reqWrite ? EEAP_WRITE : EEAP_READ;
          end
        end
        EEAP_READ: begin
          state_q <= EEAP_DONE;
        end
        EEAP_WRITE: begin
          state_q <= EEAP_DONE;
        end
        EEAP_DONE: begin
          state_q <= EEAP_IDLE;
        end
        default: begin
          state_q <= EEAP_IDLE;
        end
      endcase
    end
  end

  // Request capture; bypass is sampled per access so it cannot change mid-way.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      addr_q   <= '0;
      wdata_q  <= WORD_RST;
      write_q  <= 1'b0;
      bypass_q <= 1'b0;
    end else if (state_q == EEAP_IDLE && reqValid) begin
      addr_q   <= reqAddr;
      wdata_q  <= reqWdata;
      write_q  <= reqWrite;
      bypass_q <= eccBypass;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (state_q == EEAP_WRITE) begin
      if (bypass_q) begin
        mem[addr_q] <= wdata_q;
      end else begin
        mem[addr_q] <= {genCheck, wdata_q[DATA_MSB:0]};
      end
    end
  end

  // The array is only read here, never written back, so a double error
  // leaves the stored word as it was.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rawWord_q <= WORD_RST;
    end else if (state_q == EEAP_READ) begin
      rawWord_q <= mem[addr_q];
    end
  end

  assign evSingle = readDone(state_q, write_q) && !bypass_q && decSingle;
  assign evDouble = readDone(state_q, write_q) && !bypass_q && decDouble;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rspValid_q <= 1'b0;
      rspRdata_q <= WORD_RST;
    end else begin
      rspValid_q <= state_q == EEAP_DONE;
      if (readDone(state_q, write_q)) begin
        if (bypass_q) begin
          rspRdata_q <= rawWord_q;
        end else begin
          rspRdata_q <= {{CHECK_W{1'b0}}, decData};
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_q == EEAP_IDLE) ? reqValid : (state_q != EEAP_DONE);
    end
  end

  // A new event wins over a clear in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      singleFlag_q  <= 1'b0;
      dualFlag_q    <= 1'b0;
      statusRdata_q <= 2'h0;
    end else begin
      if (statusRead) begin
        statusRdata_q <= {dualFlag_q, singleFlag_q};
      end
      singleFlag_q <= evSingle | (singleFlag_q & ~statusRead);
      dualFlag_q   <= evDouble | (dualFlag_q & ~statusRead);
    end
  end

  // The diagnostic output state holds until reset.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      outHighZ_q <= 1'b0;
    end else if (evDouble) begin
      outHighZ_q <= 1'b1;
    end
  end

  // Checks on the access sequence, the stored words, the flags and the output state.
  state_hot_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    $onehot(state_q))
    else $error("state code not one-hot");
  busy_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    busy_q == (state_q != EEAP_IDLE))
    else $error("busy does not follow the access");
  take_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (state_q == EEAP_IDLE && reqValid) |=>
      write_q == $past(reqWrite) && bypass_q == $past(eccBypass))
    else $error("request not captured");
  hold_req_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (state_q != EEAP_IDLE) |=> $stable(bypass_q) && $stable(addr_q))
    else $error("request changed mid-access");
  single_set_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    evSingle |=> singleFlag_q)
    else $error("single flag not set");
  one_fix_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    evSingle |-> $countones(decData ^ rawWord_q[DATA_MSB:0]) <= 1)
    else $error("correction flipped more than one bit");
  dual_set_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    evDouble |=> dualFlag_q)
    else $error("dual flag not set");
  keep_word_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    evDouble |-> rawWord_q == mem[addr_q])
    else $error("stored word changed on double error");
  rd_only_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (state_q == EEAP_READ) |=> mem[$past(addr_q)] == $past(mem[addr_q]))
    else $error("read altered the stored word");
  highz_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    evDouble |=> outHighZ_q)
    else $error("output not high-impedance");
  highz_hold_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    outHighZ_q |=> outHighZ_q)
    else $error("high-impedance state dropped");
  rd_mask_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (readDone(state_q, write_q) && !bypass_q) |=> rspRdata_q[31:26] == 6'h00)
    else $error("check bits leaked");
  clean_rd_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (!decSingle && !decDouble) |-> decData == rawWord_q[DATA_MSB:0])
    else $error("clean word altered");
  rd_raw_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (readDone(state_q, write_q) && bypass_q) |=> rspRdata_q == $past(rawWord_q))
    else $error("raw word altered");
  bypass_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (readDone(state_q, write_q) && bypass_q) |=> !$rose(singleFlag_q) && !$rose(dualFlag_q))
    else $error("bypass read was checked");
  wr_data_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (state_q == EEAP_WRITE && !bypass_q) |=> mem[$past(addr_q)][DATA_MSB:0] == $past(wdata_q[DATA_MSB:0]))
    else $error("checked write data wrong");
  wr_ecc_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (state_q == EEAP_WRITE && !bypass_q) |=> mem[$past(addr_q)][31:26] == $past(genCheck))
    else $error("check bits not stored");
  wr_raw_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (state_q == EEAP_WRITE && bypass_q) |=> mem[$past(addr_q)] == $past(wdata_q))
    else $error("raw write altered");
  single_rise_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    $rose(singleFlag_q) |-> $past(evSingle))
    else $error("single flag set without error");
  dual_rise_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    $rose(dualFlag_q) |-> $past(evDouble))
    else $error("dual flag set without error");
  single_hold_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (singleFlag_q && !statusRead) |=> singleFlag_q)
    else $error("single flag lost");
  dual_hold_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (dualFlag_q && !statusRead) |=> dualFlag_q)
    else $error("dual flag lost");
  flag_clr_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (statusRead && !evSingle && !evDouble) |=> !singleFlag_q && !dualFlag_q)
    else $error("flags not cleared");
  status_cap_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    statusRead |=> statusRdata_q == {$past(dualFlag_q), $past(singleFlag_q)})
    else $error("status word wrong");
  rsp_time_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (state_q == EEAP_IDLE && reqValid) |=> ##2 rspValid_q)
    else $error("response late");
  rsp_pulse_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    rspValid_q |=> !rspValid_q)
    else $error("response longer than one cycle");
  pair_rsp_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    rspValid_q |-> !busy_q)
    else $error("busy while answering");
  rd_hold_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    !readDone(state_q, write_q) |=> $stable(rspRdata_q))
    else $error("read data changed between reads");

  // Cover points for the main scenarios.
  cov_single_c: cover property (@(posedge clk_sys) disable iff (!nrst) evSingle);
  cov_dual_c: cover property (@(posedge clk_sys) disable iff (!nrst) evDouble);
  cov_byp_c: cover property (@(posedge clk_sys) disable iff (!nrst)
    state_q == EEAP_DONE && bypass_q && !write_q);
  cov_clr_c: cover property (@(posedge clk_sys) disable iff (!nrst)
    statusRead && singleFlag_q);
  cov_wr_c: cover property (@(posedge clk_sys) disable iff (!nrst)
    state_q == EEAP_WRITE && !bypass_q);
endmodule

// *** testbench/eeap_host_model.sv ***
`timescale 1ns/1ps
// Host controller on the serial side: issues one access at a time and holds it for one clock edge.
module eeap_host_model
  import eeap_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rspValid_q,
  input  wire logic [WORD_W-1:0] rspRdata_q,
  output logic                   eccBypass,
  output logic                   reqValid,
  output logic                   reqWrite,
  output logic      [ADDR_W-1:0] reqAddr,
  output logic      [WORD_W-1:0] reqWdata,
  output logic                   statusRead
);
  initial begin
    eccBypass = 1'b0;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqAddr = '0;
    reqWdata = '0;
    statusRead = 1'b0;
  end

  // Raw writes carry host-made check bits, so the host builds the full word.
  function automatic logic [WORD_W-1:0] enc(input logic [DATA_W-1:0] d);
    logic [31:1] cw;
    logic [WORD_W-1:0] w;
    int k;
    cw = '0;
    k = 0;
    for (int p = 1; p < 32; p++) if ((p & (p - 1)) != 0) begin
      cw[p] = d[k];
      k++;
    end
    for (int i = 0; i < 5; i++) for (int p = 3; p < 32; p++) begin
      if (p[i] && (p & (p - 1)) != 0) cw[1 << i] ^= cw[p];
    end
    w = {1'b0, cw[16], cw[8], cw[4], cw[2], cw[1], d};
    w[31] = ^w;
    return w;
  endfunction

  // Called just after a rising edge; returns just after the answer edge.
  task automatic access(input logic wr, input logic byp, input logic [ADDR_W-1:0] a,
                        input logic [WORD_W-1:0] wd, output logic [WORD_W-1:0] rd);
    rd = 'x;
    eccBypass = byp;
    reqWrite = wr;
    reqAddr = a;
    reqWdata = wd;
    reqValid = 1'b1;
    @(posedge clk_sys);
    #1;
    reqValid = 1'b0;
    reqAddr = ~a;
    reqWdata = ~wd;
    repeat (8) begin
      @(posedge clk_sys);
      #1;
      if (rspValid_q === 1'b1) begin
        rd = rspRdata_q;
        break;
      end
    end
  endtask

  task automatic status_read();
    statusRead = 1'b1;
    @(posedge clk_sys);
    #1;
    statusRead = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
endmodule

// *** testbench/eeprom_ecc_access_path_tb.sv ***
`timescale 1ns/1ps
module eeprom_ecc_access_path_tb;
  import eeap_pkg::*;
  logic clk_sys, nrst, eccBypass, reqValid, reqWrite, statusRead, rspValid_q, busy_q;
  logic singleFlag_q, dualFlag_q, outHighZ_q;
  logic [1:0] statusRdata_q;
  logic [ADDR_W-1:0] reqAddr;
  logic [WORD_W-1:0] reqWdata, rspRdata_q, rd, w;
  logic [DATA_W-1:0] d;
  int n_fail;
  int total_checks;

  eeap_path dut_u (.clk_sys(clk_sys), .nrst(nrst), .eccBypass(eccBypass),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata),
    .statusRead(statusRead), .rspValid_q(rspValid_q), .rspRdata_q(rspRdata_q),
    .busy_q(busy_q), .singleFlag_q(singleFlag_q), .dualFlag_q(dualFlag_q),
    .statusRdata_q(statusRdata_q), .outHighZ_q(outHighZ_q));
  eeap_host_model host_u (.clk_sys(clk_sys), .rspValid_q(rspValid_q),
    .rspRdata_q(rspRdata_q), .eccBypass(eccBypass), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata), .statusRead(statusRead));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic do_reset();
    nrst = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
  endtask

  initial begin
    #400000;
    n_fail++;
    wrap_up();
  end

  initial begin
    n_fail = 0;
    total_checks = 0;
    void'($urandom(32'h8061));
    do_reset();
    chk({25'h0, busy_q, rspValid_q, statusRdata_q, outHighZ_q, dualFlag_q, singleFlag_q}, 32'h0);
    for (int i = 0; i < 8; i++) begin
      d = DATA_W'($urandom);
      w = $urandom;
      host_u.access(1'b1, 1'b0, ADDR_W'(i), {w[31:26], d}, rd);
      host_u.access(1'b0, 1'b1, ADDR_W'(i), '0, rd);
      chk(rd, host_u.enc(d));
      host_u.access(1'b0, 1'b0, ADDR_W'(i), '0, rd);
      chk(rd, {6'h00, d});
      chk({31'h0, busy_q}, 32'h0);
      host_u.access(1'b1, 1'b1, ADDR_W'(i + 8), w, rd);
      host_u.access(1'b0, 1'b1, ADDR_W'(i + 8), '0, rd);
      chk(rd, w);
      host_u.access(1'b1, 1'b1, ADDR_W'(i + 16), host_u.enc(d) ^ (32'h1 << (i * 4 + 3)), rd);
      host_u.access(1'b0, 1'b0, ADDR_W'(i + 16), '0, rd);
      chk(rd, {6'h00, d});
      chk({30'h0, dualFlag_q, singleFlag_q}, 32'h1);
      host_u.status_read();
      chk({30'h0, statusRdata_q}, 32'h1);
      chk({30'h0, dualFlag_q, singleFlag_q}, 32'h0);
    end
    d = DATA_W'($urandom);
    w = host_u.enc(d) ^ 32'h0000_0011;
    host_u.access(1'b1, 1'b1, 6'h28, w, rd);
    host_u.access(1'b0, 1'b0, 6'h28, '0, rd);
    chk({30'h0, dualFlag_q, singleFlag_q}, 32'h2);
    chk({31'h0, outHighZ_q}, 32'h1);
    host_u.access(1'b0, 1'b1, 6'h28, '0, rd);
    chk(rd, w);
    host_u.status_read();
    chk({30'h0, statusRdata_q}, 32'h2);
    do_reset();
    chk({25'h0, busy_q, rspValid_q, statusRdata_q, outHighZ_q, dualFlag_q, singleFlag_q}, 32'h0);
    wrap_up();
  end
endmodule
